// ===== remote_serial_model.sv
// Behavioural far end: receive events, line level and transmit shifter
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model (
  input  wire logic       ref_clk_in,
  output logic      [9:0] ev_out,
  output logic      [7:0] char_out,
  output logic            ninth_out,
  output logic            line_out,
  output logic            shifting_out
);
  initial begin
    ev_out       = 10'h000;
    char_out     = 8'h00;
    ninth_out    = 1'b0;
    line_out     = 1'b1;
    shifting_out = 1'b0;
  end
  // Character lines are scrambled once the strobe drops
  task automatic fire(input logic [9:0] m, input logic [7:0] d);
    @(posedge ref_clk_in);
    ev_out    <= m;
    char_out  <= d;
    ninth_out <= 1'b1;
    if (m[4]) line_out <= 1'b0;
    @(posedge ref_clk_in);
    ev_out    <= 10'h000;
    char_out  <= ~d;
    ninth_out <= 1'b0;
  endtask
  task automatic ticks(input int n, input logic lvl);
    @(posedge ref_clk_in);
    line_out <= lvl;
    repeat (n) fire(10'h020, 8'h00);
  endtask
  // Shifter stays busy until told otherwise
  task automatic tx_start(input logic [9:0] m);
    @(posedge ref_clk_in);
    ev_out       <= m;
    shifting_out <= 1'b1;
    @(posedge ref_clk_in);
    ev_out <= 10'h000;
  endtask
  task automatic tx_stop;
    @(posedge ref_clk_in);
    shifting_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== serial_status_asserts.sv
// Port-level checker for the serial status and data block
`timescale 1ns/1ps
`default_nettype none
module serial_status_asserts (
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       ce_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       rx_char_done_in,
  input wire logic       tx_load_in,
  input wire logic [7:0] tx_data_out,
  input wire logic       tx_pending_out,
  input wire logic       tx_irq_out,
  input wire logic       rx_irq_out,
  input wire logic       err_irq_out
);
  localparam logic [2:0] DB = serial_status_pkg::ADDR_DATA_BUFFER;
  logic [7:0] ctl2;
  logic [7:0] ctl3;
  logic       tx_written;
  wire        wr_db = ce_in && wr_in && addr_in == DB;
  // Transmit byte has no reset value, so hold checks wait for a write
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_written <= 1'b0;
    end else if (wr_db) begin
      tx_written <= 1'b1;
    end
  end
  // Enables shadowed from bus writes, since the checker cannot see inside
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl2 <= 8'h00;
      ctl3 <= 8'h00;
    end else if (ce_in && wr_in) begin
      if (addr_in == serial_status_pkg::ADDR_CONTROL_TWO) ctl2 <= wr_data_in;
      if (addr_in == serial_status_pkg::ADDR_CONTROL_THREE) ctl3 <= wr_data_in;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_wr_loads_tx: assert property (wr_db |=> tx_pending_out && tx_data_out == $past(wr_data_in))
    else $error("data write did not reach the transmit side");
  a_tx_data_hold: assert property (tx_written && !wr_db |=> $stable(tx_data_out))
    else $error("transmit byte changed without a write");
  a_load_clears_pend: assert property (ce_in && tx_load_in && !wr_in |=> !tx_pending_out)
    else $error("pending byte not taken by the shifter");
  a_tx_empty_irq: assert property (ce_in && tx_load_in && ctl2[7] |-> ##2 tx_irq_out)
    else $error("no transmit interrupt after shifter load");
  a_rx_full_irq: assert property (ce_in && rx_char_done_in && ctl2[5] |-> ##2 rx_irq_out)
    else $error("no receive interrupt after a character");
  a_txrx_irq_gate: assert property ($past(ctl2[7:4]) == 4'h0 |-> !tx_irq_out && !rx_irq_out)
    else $error("transmit or receive interrupt while disabled");
  a_err_irq_gate: assert property ($past(ctl3[3:0]) == 4'h0 |-> !err_irq_out)
    else $error("error interrupt while disabled");
  a_read_one_cycle: assert property (ce_in && !rd_in |=> rd_data_out == 8'h00)
    else $error("read data outside the read answer cycle");
  a_unmapped_zero: assert property (ce_in && rd_in && addr_in > 3'h4 |=> rd_data_out == 8'h00)
    else $error("unmapped address read not zero");
  c_tx_irq: cover property (tx_irq_out);
  c_rx_irq: cover property (rx_irq_out);
  c_err_irq: cover property (err_irq_out);
endmodule
bind serial_status_data serial_status_asserts chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .rx_char_done_in(rx_char_done_in), .tx_load_in(tx_load_in), .tx_data_out(tx_data_out),
  .tx_pending_out(tx_pending_out), .tx_irq_out(tx_irq_out), .rx_irq_out(rx_irq_out),
  .err_irq_out(err_irq_out)
);
`default_nettype wire

// ===== serial_status_data.sv
// Status flags, flag clearing sequence and data buffer of the serial port
//
// Overview of operation
// - Transmit empty sets when buffer hands a character to the shifter; reset sets it.
// - Transmit empty clears after status one read seeing it, then a buffer write.
// - Transmitter interrupt while transmit empty and its enable are both set.
// - Transmit complete sets when empty and nothing shifting; reset sets it.
// - Transmit complete clears as soon as data, preamble or break is queued.
// - Transmitter interrupt while transmit complete and its enable are both set.
// - Receive full sets on character transfer into buffer; interrupt if enabled; reset clears.
// - Receive full clears on status one read seeing it, then buffer read.
// - Quiet line sets after 10 or 11 idle ones; interrupt if enabled.
// - Quiet line armed only by a valid character after enable or clearing; the code drops the arming when quiet sets, not when it clears.
// - Quiet line clears on status one read seeing it, then buffer read.
// - Character arriving while receive full sets overrun and is discarded.
// - Overrun raises error interrupt if enabled; cleared only if seen at status read.
// - Noise flag set on noise, interrupt if enabled, status then data read clears.
// - Framing error on zero stop bit, interrupt if enabled, sequence clears it.
// - Parity error on mismatch, interrupt if enabled, sequence clears it.
// - Break sets break, framing and receive full, clears ninth bit in nine-bit mode only; no interrupt.
// - Break clears via status two read then data read; rearms after ones.
// - Reception in progress sets on start sample zero; clears on false start or idle.
// - Buffer reads return received byte, writes give transmit byte; reset keeps contents.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module serial_status_data (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rd_data_out,
  input  wire logic       serial_rx_pin_in,
  input  wire logic       rx_enable_in,
  input  wire logic       nine_bit_mode_in,
  input  wire logic       rx_bit_tick_in,
  input  wire logic       rx_start_low_in,
  input  wire logic       rx_false_start_in,
  input  wire logic       rx_char_done_in,
  input  wire logic [7:0] rx_char_in,
  input  wire logic       rx_ninth_in,
  input  wire logic       rx_noise_in,
  input  wire logic       rx_stop_zero_in,
  input  wire logic       rx_parity_bad_in,
  input  wire logic       rx_break_in,
  input  wire logic       tx_load_in,
  input  wire logic       tx_shifting_in,
  input  wire logic       tx_queue_in,
  output logic      [7:0] tx_data_out,
  output logic            tx_pending_out,
  output logic            tx_irq_out,
  output logic            rx_irq_out,
  output logic            err_irq_out
);
  // Bus decode
  wire acc_status_one = addr_in == serial_status_pkg::ADDR_STATUS_ONE;
  wire acc_status_two = addr_in == serial_status_pkg::ADDR_STATUS_TWO;
  wire acc_data       = addr_in == serial_status_pkg::ADDR_DATA_BUFFER;
  wire acc_ctl_two    = addr_in == serial_status_pkg::ADDR_CONTROL_TWO;
  wire acc_ctl_three  = addr_in == serial_status_pkg::ADDR_CONTROL_THREE;
  wire rd_status_one  = rd_in && acc_status_one;
  wire rd_status_two  = rd_in && acc_status_two;
  wire rd_data        = rd_in && acc_data;
  wire wr_data        = wr_in && acc_data;

  // Flags and control state
  logic       tx_empty;
  logic       tx_complete;
  logic       rx_full;
  logic       quiet;
  logic       overrun;
  logic       noise;
  logic       framing;
  logic       parity;
  logic       break_seen;
  logic       rx_progress;
  logic [7:0] ctl_two;
  logic [7:0] ctl_three_en;
  logic       rx_ninth_bit;
  logic [7:0] rx_buffer;
  logic [6:0] armed;
  logic       break_armed;
  logic       break_rearm;
  logic       quiet_allowed;
  logic [3:0] ones_count;
  logic       rx_enable_d;

  // Armed bits recorded at the last status one read
  localparam int ARM_TX_EMPTY = 6;
  localparam int ARM_RX_FULL  = 5;
  localparam int ARM_QUIET    = 4;
  localparam int ARM_OVERRUN  = 3;
  localparam int ARM_NOISE    = 2;
  localparam int ARM_FRAMING  = 1;
  localparam int ARM_PARITY   = 0;

  // Receive events
  wire char_accept  = rx_char_done_in && !rx_full;
  wire char_lost    = rx_char_done_in && rx_full;
  wire break_event  = rx_break_in && !break_rearm;
  wire clr_rx_flags = rd_data;
  wire idle_len_hit = ones_count == (nine_bit_mode_in ? serial_status_pkg::IDLE_BITS_LONG
                                                      : serial_status_pkg::IDLE_BITS_SHORT);
  wire idle_event   = rx_bit_tick_in && serial_rx_pin_in && (ones_count ==
                      (nine_bit_mode_in ? serial_status_pkg::IDLE_BITS_LONG - 4'h1
                                        : serial_status_pkg::IDLE_BITS_SHORT - 4'h1));
  wire quiet_set    = idle_event && quiet_allowed;
  wire rx_en_rise   = rx_enable_in && !rx_enable_d;

  // Flags that hardware sets and the read-then-access sequence clears, except progress, which false start or idle clears
  sticky_flag_cell #(.RESET_VAL(serial_status_pkg::TX_EMPTY_RESET)) u_tx_empty (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (tx_load_in),
    .clr_in     (wr_data && armed[ARM_TX_EMPTY]),
    .flag_out   (tx_empty)
  );
  sticky_flag_cell #(.RESET_VAL(serial_status_pkg::RX_FLAG_RESET)) u_rx_full (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (char_accept || break_event),
    .clr_in     (clr_rx_flags && armed[ARM_RX_FULL]),
    .flag_out   (rx_full)
  );
  sticky_flag_cell #(.RESET_VAL(serial_status_pkg::RX_FLAG_RESET)) u_quiet (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (quiet_set),
    .clr_in     (clr_rx_flags && armed[ARM_QUIET]),
    .flag_out   (quiet)
  );
  sticky_flag_cell #(.RESET_VAL(serial_status_pkg::RX_FLAG_RESET)) u_overrun (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (char_lost),
    .clr_in     (clr_rx_flags && armed[ARM_OVERRUN]),
    .flag_out   (overrun)
  );
  sticky_flag_cell #(.RESET_VAL(serial_status_pkg::RX_FLAG_RESET)) u_noise (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (rx_noise_in),
    .clr_in     (clr_rx_flags && armed[ARM_NOISE]),
    .flag_out   (noise)
  );
  sticky_flag_cell #(.RESET_VAL(serial_status_pkg::RX_FLAG_RESET)) u_framing (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (rx_stop_zero_in || break_event),
    .clr_in     (clr_rx_flags && armed[ARM_FRAMING]),
    .flag_out   (framing)
  );
  sticky_flag_cell #(.RESET_VAL(serial_status_pkg::RX_FLAG_RESET)) u_parity (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (rx_parity_bad_in),
    .clr_in     (clr_rx_flags && armed[ARM_PARITY]),
    .flag_out   (parity)
  );
  sticky_flag_cell #(.RESET_VAL(serial_status_pkg::RX_FLAG_RESET)) u_break (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (break_event),
    .clr_in     (clr_rx_flags && break_armed),
    .flag_out   (break_seen)
  );
  sticky_flag_cell #(.RESET_VAL(serial_status_pkg::RX_FLAG_RESET)) u_progress (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (rx_start_low_in),
    .clr_in     (rx_false_start_in || idle_event),
    .flag_out   (rx_progress)
  );

  // Transmit complete: queueing wins, then idle shifter with empty buffer
  wire tx_queued     = tx_queue_in || wr_data;
  wire next_tx_compl = tx_queued ? 1'b0 :
                       (tx_empty && !tx_shifting_in) ? 1'b1 :
                       tx_complete;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_complete <= serial_status_pkg::TX_COMPLETE_RESET;
    end else if (ce_in) begin
      tx_complete <= next_tx_compl;
    end
  end

  // Sequence recording; a new status read replaces the old record
  wire [6:0] seen_one = {tx_empty, rx_full, quiet, overrun, noise, framing, parity};
  wire [6:0] next_armed = rd_status_one ? seen_one :
                          (rd_data ? (armed & 7'h40) :
                          (wr_data ? (armed & 7'h3f) : armed));
  wire next_break_armed = rd_status_two ? break_seen : (rd_data ? 1'b0 : break_armed);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed       <= 7'h00;
      break_armed <= 1'b0;
    end else if (ce_in) begin
      armed       <= next_armed;
      break_armed <= next_break_armed;
    end
  end

  // Break needs the line to return high before another counts
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      break_rearm <= 1'b0;
    end else if (ce_in) begin
      if (break_event) begin
        break_rearm <= 1'b1;
      end else if (serial_rx_pin_in) begin
        break_rearm <= 1'b0;
      end
    end
  end

  // Idle detection counts line-high bit times, saturating at length
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ones_count <= 4'h0;
    end else if (ce_in && rx_bit_tick_in) begin
      if (!serial_rx_pin_in) begin
        ones_count <= 4'h0;
      end else if (!idle_len_hit) begin
        ones_count <= ones_count + 4'h1;
      end
    end
  end

  // Quiet flag needs a fresh valid character first
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      quiet_allowed <= 1'b0;
      rx_enable_d   <= 1'b0;
    end else if (ce_in) begin
      rx_enable_d <= rx_enable_in;
      if (char_accept) begin
        quiet_allowed <= 1'b1;
      end else if (rx_en_rise || quiet_set) begin
        quiet_allowed <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_two      <= serial_status_pkg::CONTROL_RESET;
      ctl_three_en <= serial_status_pkg::CONTROL_RESET;
    end else if (ce_in) begin
      if (wr_in && acc_ctl_two) begin
        ctl_two <= {wr_data_in[7:4], 4'h0};
      end
      if (wr_in && acc_ctl_three) begin
        ctl_three_en <= {4'h0, wr_data_in[3:0]};
      end
    end
  end

  // Data buffer halves keep their contents through reset
  always_ff @(posedge ref_clk_in) begin
    if (ce_in) begin
      if (char_accept) begin
        rx_buffer    <= rx_char_in;
        rx_ninth_bit <= nine_bit_mode_in ? rx_ninth_in : rx_char_in[7];
      end else if (break_event && nine_bit_mode_in) begin
        rx_ninth_bit <= 1'b0;
      end
      if (wr_data) begin
        tx_data_out <= wr_data_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_pending_out <= 1'b0;
    end else if (ce_in) begin
      if (wr_data) begin
        tx_pending_out <= 1'b1;
      end else if (tx_load_in) begin
        tx_pending_out <= 1'b0;
      end
    end
  end

  // Read data mux; unmapped addresses read zero
  wire [7:0] status_one = {tx_empty, tx_complete, rx_full, quiet, overrun, noise, framing, parity};
  wire [7:0] status_two = {6'h00, break_seen, rx_progress};
  wire [7:0] ctl_three  = {rx_ninth_bit, 3'h0, ctl_three_en[3:0]};
  wire [7:0] rd_sel     = acc_status_one ? status_one :
                          acc_status_two ? status_two :
                          acc_data       ? rx_buffer :
                          acc_ctl_two    ? ctl_two :
                          acc_ctl_three  ? ctl_three : 8'h00;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (ce_in) begin
      rd_data_out <= rd_in ? rd_sel : 8'h00;
    end
  end

  // Interrupt requests; break and reception progress never request
  wire tx_req  = (tx_empty && ctl_two[serial_status_pkg::BIT_TX_EMPTY_IE]) ||
                 (tx_complete && ctl_two[serial_status_pkg::BIT_TX_DONE_IE]);
  wire rx_req  = (rx_full && ctl_two[serial_status_pkg::BIT_RX_FULL_IE]) ||
                 (quiet && ctl_two[serial_status_pkg::BIT_QUIET_IE]);
  wire err_req = (overrun && ctl_three_en[serial_status_pkg::BIT_OVERRUN_IE]) ||
                 (noise && ctl_three_en[serial_status_pkg::BIT_NOISE_IE]) ||
                 (framing && ctl_three_en[serial_status_pkg::BIT_FRAMING_IE]) ||
                 (parity && ctl_three_en[serial_status_pkg::BIT_PARITY_IE]);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_irq_out  <= 1'b0;
      rx_irq_out  <= 1'b0;
      err_irq_out <= 1'b0;
    end else if (ce_in) begin
      tx_irq_out  <= tx_req;
      rx_irq_out  <= rx_req;
      err_irq_out <= err_req;
    end
  end
endmodule
`default_nettype wire

// ===== serial_status_pkg.sv
// Constants shared by the serial port status and data logic
package serial_status_pkg;
  // Register offsets on the word-index address port
  localparam logic [2:0] ADDR_STATUS_ONE   = 3'h0;
  localparam logic [2:0] ADDR_STATUS_TWO   = 3'h1;
  localparam logic [2:0] ADDR_DATA_BUFFER  = 3'h2;
  localparam logic [2:0] ADDR_CONTROL_TWO  = 3'h3;
  localparam logic [2:0] ADDR_CONTROL_THREE = 3'h4;
  // Status one bit positions
  localparam int BIT_TX_EMPTY    = 7;
  localparam int BIT_TX_COMPLETE = 6;
  localparam int BIT_RX_FULL     = 5;
  localparam int BIT_QUIET       = 4;
  localparam int BIT_OVERRUN     = 3;
  localparam int BIT_NOISE       = 2;
  localparam int BIT_FRAMING     = 1;
  localparam int BIT_PARITY      = 0;
  // Status two bit positions
  localparam int BIT_BREAK       = 1;
  localparam int BIT_RX_PROGRESS = 0;
  // Control two bit positions
  localparam int BIT_TX_EMPTY_IE = 7;
  localparam int BIT_TX_DONE_IE  = 6;
  localparam int BIT_RX_FULL_IE  = 5;
  localparam int BIT_QUIET_IE    = 4;
  // Control three bit positions
  localparam int BIT_NINTH       = 7;
  localparam int BIT_OVERRUN_IE  = 3;
  localparam int BIT_NOISE_IE    = 2;
  localparam int BIT_FRAMING_IE  = 1;
  localparam int BIT_PARITY_IE   = 0;
  // Reset values
  localparam logic       TX_EMPTY_RESET    = 1'b1;
  localparam logic       TX_COMPLETE_RESET = 1'b1;
  localparam logic       RX_FLAG_RESET     = 1'b0;
  localparam logic [7:0] CONTROL_RESET     = 8'h00;
  // Idle line lengths in bit times
  localparam logic [3:0] IDLE_BITS_SHORT = 4'ha;
  localparam logic [3:0] IDLE_BITS_LONG  = 4'hb;
endpackage

// ===== sticky_flag_cell.sv
// One hardware-set, sequence-cleared status flag
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);
  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_out <= RESET_VAL;
    end else if (ce_in) begin
      if (set_in) begin
        flag_out <= 1'b1;
      end else if (clr_in) begin
        flag_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the serial port status and data block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [2:0] S1 = serial_status_pkg::ADDR_STATUS_ONE;
  localparam logic [2:0] S2 = serial_status_pkg::ADDR_STATUS_TWO;
  localparam logic [2:0] DB = serial_status_pkg::ADDR_DATA_BUFFER;
  localparam logic [2:0] C2 = serial_status_pkg::ADDR_CONTROL_TWO;
  localparam logic [2:0] C3 = serial_status_pkg::ADDR_CONTROL_THREE;
  logic       ref_clk_in;
  logic       rst_in;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       rx_en;
  logic       nine_bit;
  logic [7:0] rd_data;
  logic [9:0] ev;
  logic [7:0] rx_char;
  logic       rx_ninth;
  logic       line;
  logic       shifting;
  logic [7:0] tx_data;
  logic       tx_pend;
  logic       tx_irq;
  logic       rx_irq;
  logic       err_irq;
  int         failures;
  int         n_tests;
  serial_status_data dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data),
    .serial_rx_pin_in(line), .rx_enable_in(rx_en), .nine_bit_mode_in(nine_bit),
    .rx_bit_tick_in(ev[5]), .rx_start_low_in(ev[6]), .rx_false_start_in(ev[7]),
    .rx_char_done_in(ev[0]), .rx_char_in(rx_char), .rx_ninth_in(rx_ninth),
    .rx_noise_in(ev[1]), .rx_stop_zero_in(ev[2]), .rx_parity_bad_in(ev[3]),
    .rx_break_in(ev[4]), .tx_load_in(ev[8]), .tx_shifting_in(shifting), .tx_queue_in(ev[9]),
    .tx_data_out(tx_data), .tx_pending_out(tx_pend), .tx_irq_out(tx_irq),
    .rx_irq_out(rx_irq), .err_irq_out(err_irq)
  );
  remote_serial_model far (
    .ref_clk_in(ref_clk_in), .ev_out(ev), .char_out(rx_char), .ninth_out(rx_ninth),
    .line_out(line), .shifting_out(shifting)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    report_and_stop;
  end
  initial begin
    rst_in   = 1'b1;
    addr     = 3'h0;
    wdata    = 8'h00;
    wr       = 1'b0;
    rd       = 1'b0;
    rx_en    = 1'b0;
    nine_bit = 1'b1;
    failures = 0;
    n_tests  = 0;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rx_en  <= 1'b1;
    rd_reg(S1, 8'hc0);
    rd_reg(S2, 8'h00);
    wr_reg(3'h6, 8'hff);
    rd_reg(3'h7, 8'h00);
    rd_reg(C2, 8'h00);
    $display("reset test done");
    wr_reg(C2, 8'h20);
    far.fire(10'h001, 8'h5a);
    rd_reg(S1, 8'he0);
    check({7'h00, rx_irq}, 8'h01);
    rd_reg(C3, 8'h80);
    rd_reg(DB, 8'h5a);
    rd_reg(S1, 8'hc0);
    $display("receive test done");
    far.fire(10'h001, 8'h11);
    far.fire(10'h001, 8'h22);
    rd_reg(S1, 8'he8);
    rd_reg(DB, 8'h11);
    rd_reg(S1, 8'hc0);
    far.fire(10'h001, 8'h33);
    rd_reg(S1, 8'he0);
    far.fire(10'h001, 8'h44);
    rd_reg(DB, 8'h33);
    rd_reg(S1, 8'hc8);
    rd_reg(DB, 8'h33);
    rd_reg(S1, 8'hc0);
    $display("overrun test done");
    wr_reg(C3, 8'h0f);
    for (int i = 0; i < 3; i++) begin
      far.fire(10'h002 << i, 8'h00);
      rd_reg(S1, 8'hc0 | (8'h04 >> i));
      check({7'h00, err_irq}, 8'h01);
      rd_reg(DB, 8'h33);
      rd_reg(S1, 8'hc0);
    end
    $display("receive error test done");
    far.fire(10'h010, 8'h00);
    rd_reg(S1, 8'he2);
    rd_reg(S2, 8'h02);
    rd_reg(C3, 8'h0f);
    rd_reg(DB, 8'h33);
    rd_reg(S1, 8'hc0);
    rd_reg(S2, 8'h00);
    // Line never went back high, so a second break must be ignored
    far.fire(10'h010, 8'h00);
    rd_reg(S2, 8'h00);
    far.ticks(1, 1'b1);
    far.fire(10'h010, 8'h00);
    rd_reg(S2, 8'h02);
    rd_reg(S1, 8'he2);
    rd_reg(DB, 8'h33);
    rd_reg(S1, 8'hc0);
    rd_reg(S2, 8'h00);
    $display("break test done");
    far.fire(10'h001, 8'h66);
    rd_reg(S1, 8'he0);
    rd_reg(DB, 8'h66);
    far.ticks(1, 1'b0);
    far.ticks(10, 1'b1);
    rd_reg(S1, 8'hc0);
    far.ticks(1, 1'b1);
    rd_reg(S1, 8'hd0);
    rd_reg(DB, 8'h66);
    rd_reg(S1, 8'hc0);
    // Count restarts, so only the missing arming can keep quiet low
    far.ticks(1, 1'b0);
    far.ticks(11, 1'b1);
    rd_reg(S1, 8'hc0);
    far.fire(10'h040, 8'h00);
    rd_reg(S2, 8'h01);
    far.fire(10'h080, 8'h00);
    rd_reg(S2, 8'h00);
    $display("idle and progress test done");
    wr_reg(C2, 8'h30);
    @(posedge ref_clk_in);
    nine_bit <= 1'b0;
    far.fire(10'h001, 8'h7e);
    rd_reg(C3, 8'h0f);
    rd_reg(S1, 8'he0);
    rd_reg(DB, 8'h7e);
    far.ticks(1, 1'b0);
    far.ticks(9, 1'b1);
    rd_reg(S1, 8'hc0);
    far.ticks(1, 1'b1);
    rd_reg(S1, 8'hd0);
    check({7'h00, rx_irq}, 8'h01);
    rd_reg(DB, 8'h7e);
    rd_reg(S1, 8'hc0);
    check({7'h00, rx_irq}, 8'h00);
    $display("eight-bit idle test done");
    wr_reg(C2, 8'hc0);
    wr_reg(DB, 8'ha5);
    rd_reg(S1, 8'h00);
    check(tx_data, 8'ha5);
    check({7'h00, tx_pend}, 8'h01);
    check({7'h00, tx_irq}, 8'h00);
    far.tx_start(10'h100);
    wr_reg(DB, 8'h3c);
    rd_reg(S1, 8'h80);
    check({7'h00, tx_irq}, 8'h01);
    far.tx_stop;
    wr_reg(C2, 8'h40);
    rd_reg(S1, 8'hc0);
    check({7'h00, tx_irq}, 8'h01);
    far.tx_start(10'h200);
    rd_reg(S1, 8'h80);
    check({7'h00, tx_irq}, 8'h00);
    far.tx_stop;
    $display("transmit test done");
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd_reg(DB, 8'h7e);
    check(tx_data, 8'h3c);
    check({7'h00, tx_pend}, 8'h00);
    rd_reg(S1, 8'hc0);
    rd_reg(C2, 8'h00);
    $display("mid-run reset test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
